//--- scp_sync_port_capture.sv
// Synchronous strobe capture, busy handshake and port drivers
//
// Contract
// - Positive strobe select captures on each rising strobe edge.
// - Negative strobe select captures on each falling strobe edge instead.
// - Strobe select defaults to rising edge after reset.
// - Strobe is watched only while armed; other transitions are ignored.
// - Enable mask drives listed ports 0..11 and floats all others.
// - An enabled port drives its most recently written value.
// - An unwritten port drives all eight bits low when enabled.
// - Reading an enabled port returns the value it drives.
// - Writes to floating ports are stored and appear once enabled.
// - Configuring a capture port clears its buffered contents.
// - Each armed active edge stores inputs at next buffer slot, 256 max.
// - Vector count ranges 0..256; zero leaves the port idle.
// - Bit capture records only the selected bit positions 0..7.
// - Software may start and stop a test anytime via arm flag.
// - Arm clears itself when all sync ports finish their counts.
// - Buffers are readable after arm is cleared manually as well.
// - Busy is high while processing, or low with negative polarity.
// - Setting arm restarts every port at its first buffer slot.
// - Sync ports are a contiguous group from port 0, count 0..12.
// - Word capture: low byte from even port, high from next odd.
//
// Implementation choices: register access over AHB-Lite and the register offsets.
module scp_sync_port_capture #(
  parameter int NPORTS = scp_pkg::NPORTS,
  parameter int DEPTH = scp_pkg::DEPTH
) (
  input wire logic ref_clk, // System clock, 50 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  output logic [31:0] hrdata, // AHB read data
  input wire logic [NPORTS-1:0][7:0] port_in, // Port pin levels
  output logic [NPORTS-1:0][7:0] port_out, // Port drive values
  output logic [NPORTS-1:0] port_oe, // Port driver enables
  input wire logic capture_strobe_in, // Capture strobe pin
  output logic busy_out // Busy handshake pin
);

  localparam int CW = $clog2(DEPTH) + 1;
  localparam int AW = CW - 1;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [1:0] strobe_sync;
  logic strobe_prev;
  logic [NPORTS-1:0][7:0] pin_s1;
  logic [NPORTS-1:0][7:0] pin_s2;

  // Pins are asynchronous: two stages before any logic reads them
  always_ff @(posedge ref_clk) begin
    strobe_sync <= {strobe_sync[0], capture_strobe_in};
    strobe_prev <= strobe_sync[1];
    pin_s1 <= port_in;
    pin_s2 <= pin_s1;
  end

  // ************************************************************
  // Control state
  // ************************************************************
  logic arm;
  logic falling_select;
  logic busy_neg;
  logic [3:0] sync_cnt;
  logic cap_pend;
  logic [NPORTS-1:0][7:0] port_val;

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  logic ph_wr;
  logic [7:0] ph_addr;
  wire take = hsel & htrans[1] & hready;
  wire wr_ctrl = ph_wr && ph_addr == scp_pkg::OFF_CTRL;
  wire wr_en_reg = ph_wr && ph_addr == scp_pkg::OFF_ENABLE;
  wire wr_setup = ph_wr && ph_addr == scp_pkg::OFF_SETUP && !arm;
  wire wr_rsel = ph_wr && ph_addr == scp_pkg::OFF_RSEL;
  wire wr_page = ph_wr && ph_addr[7:6] == scp_pkg::PORT_PAGE;
  wire [3:0] wr_port = ph_addr[5:2];

  // Zero wait states: every data phase completes in one cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ph_wr <= 1'b0;
      ph_addr <= 8'h00;
    end else if (hready) begin
      ph_wr <= take & hwrite;
      ph_addr <= haddr[7:0];
    end
  end

  // Setup word fields
  wire [3:0] su_port = hwdata[scp_pkg::SU_PORT_LSB +: 4];
  wire [1:0] su_mode_raw = hwdata[scp_pkg::SU_MODE_LSB +: 2];
  wire [7:0] su_mask = hwdata[scp_pkg::SU_MASK_LSB +: 8];
  wire [8:0] su_cnt_raw = hwdata[scp_pkg::SU_CNT_LSB +: 9];
  wire [8:0] su_cnt =
    (su_cnt_raw > 9'(DEPTH)) ? 9'(DEPTH) : su_cnt_raw;
  wire [3:0] new_sync = hwdata[scp_pkg::CTRL_SYNC_LSB +: 4];
  wire [3:0] new_sync_lim =
    (new_sync > 4'(NPORTS)) ? 4'(NPORTS) : new_sync;
  // Only a disarmed-to-armed write restarts the pointers
  wire arm_start = wr_ctrl && hwdata[scp_pkg::CTRL_ARM] && !arm;

  // ************************************************************
  // Edge detection and capture
  // ************************************************************
  wire rise = strobe_sync[1] & ~strobe_prev;
  wire fall = ~strobe_sync[1] & strobe_prev;
  // Edges inside the busy cycle are dropped; strobe is much slower
  wire act_edge = arm && !cap_pend &&
    (falling_select ? fall : rise);

  logic [NPORTS-1:0] act_w;
  logic [NPORTS-1:0] done_w;
  logic [NPORTS-1:0][CW-1:0] ptr_w;
  logic [NPORTS-1:0][1:0] mode_w;
  logic [NPORTS-1:0][7:0] rd_byte;
  logic [AW-1:0] ridx;
  logic [3:0] rport;
  wire all_done = &done_w;

  for (genvar g = 0; g < NPORTS; g++) begin : gp
    scp_pkg::scp_cfg_t c;
    logic [CW-1:0] p;
    logic [7:0] bank [DEPTH];
    logic comp_act;
    wire in_sync = 4'(g) < sync_cnt;
    wire own_act = in_sync && c.mode != scp_pkg::SCP_OFF &&
      p < c.cnt;
    wire hit = wr_setup && su_port == 4'(g);
    wire word_odd = (g % 2 == 1) && su_mode_raw == scp_pkg::SCP_WORD;
    // A word pair owns both ports; redefining either half drops the other
    wire kill = wr_setup && (((g % 2 == 1) && su_port == 4'(g - 1) &&
      su_mode_raw == scp_pkg::SCP_WORD) || ((g % 2 == 0) &&
      su_port == 4'(g + 1) && c.mode == scp_pkg::SCP_WORD));
    // Ports joining or leaving the sync group lose their setup
    wire reinit = wr_ctrl && !arm &&
      ((4'(g) < sync_cnt) != (4'(g) < new_sync_lim));
    wire [CW-1:0] wr_ptr = comp_act ? ptr_w[g-(g%2)] : p;
    wire [7:0] wr_data = (c.mode == scp_pkg::SCP_BIT) ?
      (pin_s2[g] & c.mask) : pin_s2[g];

    if (g % 2 == 1) begin : odd
      assign comp_act = act_w[g-1] &&
        mode_w[g-1] == scp_pkg::SCP_WORD;
    end else begin : even
      assign comp_act = 1'b0;
    end

    assign act_w[g] = own_act;
    assign done_w[g] = !own_act;
    assign ptr_w[g] = p;
    assign mode_w[g] = c.mode;
    assign rd_byte[g] = bank[ridx];

    always_ff @(posedge ref_clk) begin
      if (srst || reinit || kill) begin
        c <= scp_pkg::CFG_RST;
      end else if (hit) begin
        c.mode <= word_odd ? scp_pkg::SCP_OFF :
          scp_pkg::scp_mode_t'(su_mode_raw);
        c.mask <= su_mask;
        c.cnt <= su_cnt;
      end
    end

    // Fill pointer doubles as the buffer's valid length
    always_ff @(posedge ref_clk) begin
      if (srst || hit || arm_start) begin
        p <= '0;
      end else if (cap_pend && own_act) begin
        p <= p + 1'b1;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (cap_pend && (own_act || comp_act)) begin
        bank[wr_ptr[AW-1:0]] <= wr_data;
      end
    end
  end

  // ************************************************************
  // Arm, busy and driver registers
  // ************************************************************
  wire next_pend = act_edge;
  // Auto-disarm waits for the last store so no vector is dropped
  wire auto_off = arm && all_done && !cap_pend;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      arm <= 1'b0;
      falling_select <= 1'b0;
      busy_neg <= 1'b0;
      sync_cnt <= scp_pkg::SYNC_RST;
    end else if (wr_ctrl) begin
      arm <= hwdata[scp_pkg::CTRL_ARM];
      if (!arm) begin
        falling_select <= hwdata[scp_pkg::CTRL_FALL];
        busy_neg <= hwdata[scp_pkg::CTRL_BUSYNEG];
        sync_cnt <= new_sync_lim;
      end
    end else if (auto_off) begin
      arm <= 1'b0;
    end
  end

  // Busy comes from a flop so the pin never glitches on decode
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cap_pend <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      cap_pend <= next_pend;
      busy_out <= busy_neg ^ next_pend;
    end
  end

  // Written mask replaces every enable at once
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      port_oe <= '0;
    end else if (wr_en_reg) begin
      port_oe <= hwdata[NPORTS-1:0];
    end
  end

  for (genvar q = 0; q < NPORTS; q++) begin : gd
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        port_val[q] <= scp_pkg::PORT_RST;
      end else if (wr_page && wr_port == 4'(q)) begin
        port_val[q] <= hwdata[7:0];
      end
    end
  end

  assign port_out = port_val;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ridx <= '0;
      rport <= 4'h0;
    end else if (wr_rsel) begin
      ridx <= hwdata[scp_pkg::RS_IDX_LSB +: AW];
      rport <= hwdata[scp_pkg::RS_PORT_LSB +: 4];
    end
  end

  // ************************************************************
  // Read multiplexer
  // ************************************************************
  // Readout is refused while armed so software never sees a half test
  wire rport_ok = rport < 4'(NPORTS) && !arm;
  wire [3:0] rhi = rport + 4'h1;
  wire lo_ok = rport_ok && {1'b0, ridx} < ptr_w[rport];
  wire hi_ok = lo_ok && !rport[0] && rhi < 4'(NPORTS) &&
    mode_w[rport] == scp_pkg::SCP_WORD;
  wire [7:0] rd_lo = lo_ok ? rd_byte[rport] : 8'h00;
  wire [7:0] rd_hi = hi_ok ? rd_byte[rhi] : 8'h00;
  wire [3:0] a_port = haddr[5:2];
  wire a_page = haddr[7:6] == scp_pkg::PORT_PAGE &&
    a_port < 4'(NPORTS);
  wire [7:0] pin_rd = port_oe[a_port] ? port_val[a_port] :
    pin_s2[a_port];
  wire [31:0] rd_ctrl = {20'h0, sync_cnt, 5'h0, busy_neg,
    falling_select, arm};
  wire [31:0] rd_stat = {20'h0, sync_cnt, 6'h0, cap_pend, arm};
  // Unmapped offsets read zero
  wire [31:0] rd_mux =
    (haddr[7:0] == scp_pkg::OFF_CTRL) ? rd_ctrl :
    (haddr[7:0] == scp_pkg::OFF_STATUS) ? rd_stat :
    (haddr[7:0] == scp_pkg::OFF_ENABLE) ? 32'(port_oe) :
    (haddr[7:0] == scp_pkg::OFF_RSEL) ?
      {16'h0, 8'(ridx), 4'h0, rport} :
    (haddr[7:0] == scp_pkg::OFF_RDATA) ? {16'h0, rd_hi, rd_lo} :
    a_page ? {24'h0, pin_rd} : 32'h0;

  // Read data launched at the address edge, standing one data phase
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hrdata <= 32'h0;
    end else if (hready) begin
      hrdata <= (take && !hwrite) ? rd_mux : 32'h0;
    end
  end

endmodule

//--- scp_pkg.sv
// Constants and types shared by the synchronous port capture block
package scp_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NPORTS = 12;
  localparam int DEPTH = 256;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ENABLE = 8'h08;
  localparam logic [7:0] OFF_SETUP = 8'h0c;
  localparam logic [7:0] OFF_RSEL = 8'h10;
  localparam logic [7:0] OFF_RDATA = 8'h14;
  localparam logic [1:0] PORT_PAGE = 2'h1;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTRL_ARM = 0;
  localparam int CTRL_FALL = 1;
  localparam int CTRL_BUSYNEG = 2;
  localparam int CTRL_SYNC_LSB = 8;
  localparam int SU_PORT_LSB = 0;
  localparam int SU_MODE_LSB = 4;
  localparam int SU_MASK_LSB = 8;
  localparam int SU_CNT_LSB = 16;
  localparam int RS_PORT_LSB = 0;
  localparam int RS_IDX_LSB = 8;
  localparam int ST_ARM = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_SYNC_LSB = 8;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [3:0] SYNC_RST = 4'h0;
  localparam logic [7:0] PORT_RST = 8'h00;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    SCP_BYTE = 2'b00,
    SCP_WORD = 2'b01,
    SCP_BIT = 2'b10,
    SCP_OFF = 2'b11
  } scp_mode_t;

  typedef struct packed {
    scp_mode_t mode;
    logic [7:0] mask;
    logic [8:0] cnt;
  } scp_cfg_t;

  localparam scp_cfg_t CFG_RST = '{SCP_OFF, 8'h00, 9'h000};

endpackage

//--- scp_asserts.sv
// Concurrent checks on the bus response and the port side of the capture block
module scp_asserts #(
  parameter int NPORTS = 12
) (
  input wire logic ref_clk, // Clock
  input wire logic srst, // Reset
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Type
  input wire logic hwrite, // Write
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Ready
  input wire logic hresp, // Response
  input wire logic [NPORTS-1:0][7:0] port_out, // Drive values
  input wire logic [NPORTS-1:0] port_oe, // Enables
  input wire logic capture_strobe_in, // Strobe
  input wire logic busy_out // Busy
);
  logic wph;
  logic pol;
  logic act;
  logic [7:0] wa;
  // ******
  // Bus snoop
  // ******
  // Assumes busy polarity is only rewritten while disarmed
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wph <= 1'b0;
      pol <= 1'b0;
      wa <= 8'h00;
    end else if (hready) begin
      wph <= hsel & htrans[1] & hwrite;
      wa <= haddr[7:0];
      if (wph && wa == scp_pkg::OFF_CTRL) begin
        pol <= hwdata[scp_pkg::CTRL_BUSYNEG];
      end
    end
  end
  assign act = busy_out ^ pol;
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  reset_float_a: assert property ($fell(srst) |-> port_oe == '0)
    else $error("drivers on after reset");
  reset_low_a: assert property ($fell(srst) |->
    !busy_out && port_out == '0)
    else $error("outputs not low after reset");
  busy_one_a: assert property (act |=> !act)
    else $error("busy longer than one cycle");
  busy_cause_a: assert property ($rose(act) && $stable(pol) |->
    $past(capture_strobe_in, 3) != $past(capture_strobe_in, 4))
    else $error("busy without strobe edge");
  oe_load_a: assert property (wph && hready && wa == scp_pkg::OFF_ENABLE
    |=> port_oe == $past(hwdata[NPORTS-1:0]))
    else $error("enables not loaded");
  oe_hold_a: assert property ($changed(port_oe) |->
    $past(wph && wa == scp_pkg::OFF_ENABLE))
    else $error("enables changed by themselves");
  out_hold_a: assert property ($changed(port_out) |->
    $past(wph && wa[7:6] == scp_pkg::PORT_PAGE))
    else $error("drive value changed by itself");
endmodule

bind scp_sync_port_capture scp_asserts #(.NPORTS(NPORTS)) scp_asserts_inst (
  .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hresp(hresp), .port_out(port_out), .port_oe(port_oe),
  .capture_strobe_in(capture_strobe_in), .busy_out(busy_out)
);

//--- scp_tester.sv
// Behavioural test equipment: capture strobe and port pin levels
module scp_tester (
  output logic capture_strobe_in, // Strobe
  output logic [11:0][7:0] port_in, // Pin levels
  input wire logic busy_out // Busy
);
  timeunit 1ns;
  timeprecision 1ns;
  int busy_rises = 0;
  initial begin
    capture_strobe_in = 1'b0;
    port_in = '0;
  end
  // Only counted for the bench; the level is never acted on
  always @(posedge busy_out) busy_rises++;
  // Strobe stands still between vectors; pins invert once let go
  // Changes land 5 or 10 ns after a rising clock edge so sampling never races
  task automatic vec(input logic [15:0] d, input logic fall);
    #5 port_in[1:0] = d;
    capture_strobe_in = fall;
    #80 capture_strobe_in = ~fall;
    #80 capture_strobe_in = fall;
    #40 port_in[1:0] = ~d;
  endtask
endmodule

//--- tb_top.sv
// Self-checking bench for the synchronous port capture block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rd_pend = 1'b0;
  logic pin_pend = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [3:0] psel = 4'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, busy_out, strobe;
  logic [31:0] hrdata, got, exp;
  logic [11:0][7:0] port_in, port_out;
  logic [11:0] port_oe;
  logic [31:0] q[$];
  logic [7:0] a, m;
  logic [15:0] w;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;

  scp_sync_port_capture scp_sync_port_capture_inst (
    .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .port_in(port_in), .port_out(port_out),
    .port_oe(port_oe), .capture_strobe_in(strobe), .busy_out(busy_out)
  );
  scp_tester tester_inst (
    .capture_strobe_in(strobe), .port_in(port_in), .busy_out(busy_out)
  );

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  // ******
  // Drivers and result watcher
  // ******
  task automatic xf(input logic wr, input logic [7:0] ad,
                    input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_pend <= ~wr;
    if (!wr) q.push_back(d);
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd_pend <= 1'b0;
  endtask

  task automatic rb(input logic [7:0] idx, input logic [31:0] e);
    xf(1'b1, scp_pkg::OFF_RSEL, {16'h0, idx, 8'h00});
    xf(1'b0, scp_pkg::OFF_RDATA, e);
  endtask

  // Expected pins: busy rises 31:21, busy 20, enables, drive value
  task automatic pc(input logic [3:0] p, input logic [31:0] e);
    @(posedge ref_clk);
    psel <= p;
    pin_pend <= 1'b1;
    q.push_back(e);
    @(posedge ref_clk);
    pin_pend <= 1'b0;
  endtask

  always @(posedge ref_clk) begin
    if (rd_pend === 1'b1 || pin_pend === 1'b1) begin
      exp = q.pop_front();
      got = pin_pend ? {11'(tester_inst.busy_rises), busy_out, port_oe,
        port_out[psel]} : hrdata;
      num_checks++;
      if (got !== exp) begin
        errors++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      report_and_stop();
    end
  end

  // ******
  // Tests
  // ******
  initial begin
    void'($urandom(32'h40f8597f));
    a = $urandom;
    m = $urandom;
    w = $urandom;
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    xf(1'b0, scp_pkg::OFF_CTRL, 32'h0);
    pc(4'h0, 32'h0);
    $display("reset test done");
    xf(1'b1, 8'h4c, {24'h0, a});
    xf(1'b1, 8'h5c, {24'h0, ~a});
    xf(1'b1, scp_pkg::OFF_ENABLE, 32'h28);
    pc(4'h3, {12'h0, 12'h028, a});
    pc(4'h5, {12'h0, 12'h028, 8'h00});
    xf(1'b0, 8'h4c, {24'h0, a});
    xf(1'b1, scp_pkg::OFF_ENABLE, 32'h80);
    pc(4'h7, {12'h0, 12'h080, ~a});
    xf(1'b1, scp_pkg::OFF_ENABLE, 32'h0);
    $display("driver test done");
    xf(1'b1, scp_pkg::OFF_CTRL, 32'h200);
    xf(1'b1, scp_pkg::OFF_SETUP, 32'h0002_0010);
    xf(1'b1, scp_pkg::OFF_CTRL, 32'h201);
    tester_inst.vec(w, 1'b0);
    tester_inst.vec(~w, 1'b0);
    xf(1'b0, scp_pkg::OFF_STATUS, 32'h200);
    rb(8'h00, {16'h0, w});
    rb(8'h01, {16'h0, ~w});
    rb(8'h02, 32'h0);
    pc(4'h0, 32'h0040_0000);
    $display("rising word test done");
    xf(1'b1, scp_pkg::OFF_SETUP, {7'h0, 9'h002, m, 8'h20});
    xf(1'b1, scp_pkg::OFF_CTRL, 32'h206);
    tester_inst.vec(16'h00ff, 1'b1);
    pc(4'h0, 32'h0070_0000);
    xf(1'b1, scp_pkg::OFF_CTRL, 32'h207);
    tester_inst.vec({8'h00, a}, 1'b1);
    pc(4'h0, 32'h0090_0000);
    xf(1'b0, scp_pkg::OFF_STATUS, 32'h201);
    xf(1'b1, scp_pkg::OFF_CTRL, 32'h206);
    rb(8'h00, {24'h0, a & m});
    rb(8'h01, 32'h0);
    $display("falling bit test done");
    report_and_stop();
  end
endmodule
